// ---- src/tcc_pkg.sv ----
package tcc_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses on APB).
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL1 = 8'h00;   // Master enables and PWM mode.
  localparam logic [7:0] OFS_CTRL3 = 8'h04;   // Per-channel enables.
  localparam logic [7:0] OFS_CMP2 = 8'h08;    // Second compare value.
  localparam logic [7:0] OFS_STATUS = 8'h0C;  // Sticky event flags, read only.
  localparam logic [7:0] OFS_CLEAR = 8'h10;   // Write one to clear flags.
  localparam logic [7:0] OFS_IRQEN = 8'h14;   // Summary interrupt enable.
  localparam logic [7:0] OFS_REQ = 8'h18;     // Live gated requests, read only.

  // ----------------------------------------------------------------
  // Field positions.
  // ----------------------------------------------------------------
  localparam int CTRL1_CAP_MASTER = 0;  // Capture master enable bit.
  localparam int CTRL1_CMP_MASTER = 1;  // Compare master enable bit.
  localparam int CTRL1_PWM = 2;         // PWM mode select bit.
  localparam int CTRL3_CAP1 = 7;        // Capture 1 enable.
  localparam int CTRL3_CMP1 = 6;        // Compare 1 enable.
  localparam int CTRL3_CAP2 = 5;        // Capture 2 enable.
  localparam int CTRL3_CMP2 = 4;        // Compare 2 enable.

  // Flag indices in the status word.
  localparam int FLG_CAP1 = 0;  // Capture 1 flag.
  localparam int FLG_CAP2 = 1;  // Capture 2 flag.
  localparam int FLG_CMP1 = 2;  // Compare 1 flag.
  localparam int FLG_CMP2 = 3;  // Compare 2 flag.
  localparam int NUM_FLAGS = 4; // Number of event flags.

  // Reset values.
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;  // Every register clears.

endpackage : tcc_pkg

// ---- src/tcc_flag_if.sv ----
`timescale 1ns/1ps
// Carries the event flags and their gating enables between modules.
interface tcc_flag_if;
  logic [3:0] flag;     // Sticky event flags.
  logic [3:0] enable;   // Effective enable for each flag.
  logic [3:0] request;  // Gated interrupt requests.
  modport core (output flag, output enable, input request);
  modport gate (input flag, input enable, output request);
endinterface : tcc_flag_if

// ---- src/tcc_gate.sv ----
`timescale 1ns/1ps
// Per-flag gating of events onto interrupt requests.
module tcc_gate (
  // Flag and enable carrier.
  tcc_flag_if.gate fl
);

  // ----------------------------------------------------------------
  // Gating
  // ----------------------------------------------------------------
  // Each request stands while its flag and its effective enable are set.
  genvar i;
  generate
    for (i = 0; i < tcc_pkg::NUM_FLAGS; i++) begin : g_req
      assign fl.request[i] = fl.flag[i] & fl.enable[i];
    end
  endgenerate

endmodule // tcc_gate

// ---- src/tcc_core.sv ----
`timescale 1ns/1ps
// Interrupt gating for timer capture and compare channels, with APB access.
// Each timer event sets a sticky flag. A flag reaches its interrupt request when
// the effective enable of its channel is set: the master enable of the function
// while that is set, otherwise the channel's own enable bit. The requests drive
// the capture and compare outputs one edge later, and the summary output adds a
// software mask on top of them.
// In PWM mode hardware never sets the first compare flag, while every match of
// the counter with the second compare value sets the second compare flag.
// The second compare match sets its flag outside PWM mode as well; software that
// does not want that interrupt leaves the compare master and the second compare enable clear.
// A flag stays set while the counter rests on the match value, so a clear in that
// time is overruled at once; clear it after the counter has moved on.
// Register access takes no wait states and never reports an error.
module tcc_core #(
  parameter int CNT_W = 16  // Counter and compare width.
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic arst_n,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Timer events, same clock domain.
  input wire logic capture1Event,
  input wire logic capture2Event,
  input wire logic compare1Match,
  input wire logic [CNT_W-1:0] counterValue,
  // Configuration seen by the counter.
  output logic pwmMode,
  output logic [CNT_W-1:0] compare2Value,
  // Interrupt outputs.
  output logic captureIrq,
  output logic compareIrq,
  output logic irq
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic capMaster;            // Capture master enable.
  logic cmpMaster;            // Compare master enable.
  logic [7:0] ctrlThird;      // Per-channel enables in bits 7..4.
  logic [3:0] irqEnable;      // Summary interrupt enable.
  logic compare2Hit;          // Counter equals the second compare value.
  logic compare1Set;          // Hardware set of compare 1 flag.
  logic apbWrite;             // Write access phase.
  logic apbRead;              // Read access phase.
  logic [3:0] next_flag;      // Flag value for the next edge.
  logic [3:0] setVec;         // Event set vector.
  logic [3:0] clrVec;         // Software clear vector.
  logic [3:0] flagReg;        // Sticky flags.
  logic capMask1;             // Effective capture 1 enable.
  logic capMask2;             // Effective capture 2 enable.
  logic cmpMask1;             // Effective compare 1 enable.
  logic cmpMask2;             // Effective compare 2 enable.

  tcc_flag_if fl ();  // Flag gating carrier.

  // The slave answers in the first access cycle and never errs.
  // A write takes effect at the edge that ends its access phase.
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign apbWrite = psel & penable & pwrite;
  assign apbRead = psel & penable & ~pwrite;

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  // Control writes from software.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      capMaster <= 1'b0;
      cmpMaster <= 1'b0;
      pwmMode <= 1'b0;
      ctrlThird <= '0;
      compare2Value <= '0;
      irqEnable <= '0;
    end else if (apbWrite) begin
      case (paddr)
        tcc_pkg::OFS_CTRL1: begin
          capMaster <= pwdata[tcc_pkg::CTRL1_CAP_MASTER];
          cmpMaster <= pwdata[tcc_pkg::CTRL1_CMP_MASTER];
          pwmMode <= pwdata[tcc_pkg::CTRL1_PWM];
        end
        tcc_pkg::OFS_CTRL3: begin
          // Only the four enable bits are kept.
          ctrlThird <= {pwdata[tcc_pkg::CTRL3_CAP1:tcc_pkg::CTRL3_CMP2], 4'h0};
        end
        tcc_pkg::OFS_CMP2: begin
          compare2Value <= pwdata[CNT_W-1:0];
        end
        tcc_pkg::OFS_IRQEN: begin
          irqEnable <= pwdata[3:0];
        end
        default: begin
          // Other offsets store nothing.
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Events
  // ----------------------------------------------------------------
  // Second compare matches the counter in every mode, so PWM periods interrupt.
  assign compare2Hit = (counterValue == compare2Value);
  // Hardware never sets compare 1 in PWM mode.
  assign compare1Set = compare1Match & ~pwmMode;

  // Collect events and software clears.
  always_comb begin
    setVec = '0;
    setVec[tcc_pkg::FLG_CAP1] = capture1Event;
    setVec[tcc_pkg::FLG_CAP2] = capture2Event;
    setVec[tcc_pkg::FLG_CMP1] = compare1Set;
    setVec[tcc_pkg::FLG_CMP2] = compare2Hit;
    clrVec = '0;
    if (apbWrite && paddr == tcc_pkg::OFS_CLEAR) begin
      clrVec = pwdata[3:0];
    end
    // A set in the clearing cycle wins.
    next_flag = (flagReg & ~clrVec) | setVec;
  end

  // Sticky flags.
  // A flag falls only through a software clear, and an event in the same cycle
  // keeps it set, so no event is lost to a clear that races it.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      flagReg <= '0;
    end else begin
      flagReg <= next_flag;
    end
  end

  // ----------------------------------------------------------------
  // Effective enables
  // ----------------------------------------------------------------
  // Master set overrides the channel bits; master clear defers to them.
  // A function with its master and both channel bits clear stays silent, and
  // the second compare enable doubles as the gate of the PWM match interrupt.
  assign capMask1 = capMaster | ctrlThird[tcc_pkg::CTRL3_CAP1];
  assign capMask2 = capMaster | ctrlThird[tcc_pkg::CTRL3_CAP2];
  assign cmpMask1 = cmpMaster | ctrlThird[tcc_pkg::CTRL3_CMP1];
  // Also the PWM match gate.
  assign cmpMask2 = cmpMaster | ctrlThird[tcc_pkg::CTRL3_CMP2];

  // Hand the flags and their effective enables to the per-flag gate.
  assign fl.flag = flagReg;
  assign fl.enable = {cmpMask2, cmpMask1, capMask2, capMask1};

  tcc_gate u_gate (
    .fl(fl)
  );

  // Requests are registered so the outputs come from flip-flops.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      captureIrq <= 1'b0;
      compareIrq <= 1'b0;
      irq <= 1'b0;
    end else begin
      captureIrq <= |fl.request[1:0];
      compareIrq <= |fl.request[3:2];
      irq <= |(fl.request & irqEnable);
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  // Read mux, registered for the access cycle after setup.
  // Latching at the setup edge lets the slave answer with no wait state, and
  // the word then stands unchanged until the next read setup.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prdata <= tcc_pkg::RST_ZERO;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        tcc_pkg::OFS_CTRL1: prdata <= {29'h0, pwmMode, cmpMaster, capMaster};
        tcc_pkg::OFS_CTRL3: prdata <= {24'h0, ctrlThird};
        tcc_pkg::OFS_CMP2: prdata <= 32'(compare2Value);
        tcc_pkg::OFS_STATUS: prdata <= {28'h0, flagReg};
        tcc_pkg::OFS_IRQEN: prdata <= {28'h0, irqEnable};
        tcc_pkg::OFS_REQ: prdata <= {28'h0, fl.request};
        default: prdata <= tcc_pkg::RST_ZERO;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Every check is clocked by clk and stays quiet while reset is low.

  // The capture master lets the first capture flag through.
  a_master_cap: assert property (@(posedge clk) disable iff (!arst_n)
    (capMaster && flagReg[tcc_pkg::FLG_CAP1]) |=> captureIrq)
    else $error("Capture master did not raise request.");

  // The capture master lets the second capture flag through.
  a_master_cap2: assert property (@(posedge clk) disable iff (!arst_n)
    (capMaster && flagReg[tcc_pkg::FLG_CAP2]) |=> captureIrq)
    else $error("Capture master did not raise second request.");

  // The compare master lets the first compare flag through.
  a_master_cmp: assert property (@(posedge clk) disable iff (!arst_n)
    (cmpMaster && flagReg[tcc_pkg::FLG_CMP1]) |=> compareIrq)
    else $error("Compare master did not raise request.");

  // A cleared compare 1 enable has no effect while the compare master is set.
  a_chan_ignored: assert property (@(posedge clk) disable iff (!arst_n)
    (cmpMaster && flagReg[tcc_pkg::FLG_CMP1] && !ctrlThird[tcc_pkg::CTRL3_CMP1])
    |=> compareIrq)
    else $error("Channel enable was not ignored under master.");

  // A cleared capture 1 enable has no effect while the capture master is set.
  a_cap_ignored: assert property (@(posedge clk) disable iff (!arst_n)
    (capMaster && flagReg[tcc_pkg::FLG_CAP1] && !ctrlThird[tcc_pkg::CTRL3_CAP1])
    |=> captureIrq)
    else $error("Capture enable was not ignored under master.");

  // With the master clear, a disabled second capture stays silent.
  a_single_chan: assert property (@(posedge clk) disable iff (!arst_n)
    (!capMaster && !ctrlThird[tcc_pkg::CTRL3_CAP2] && flagReg[tcc_pkg::FLG_CAP2]
    && !flagReg[tcc_pkg::FLG_CAP1]) |=> !captureIrq)
    else $error("Disabled channel raised a request.");

  // With the master clear, an enabled first capture interrupts on its own.
  a_single_cap1: assert property (@(posedge clk) disable iff (!arst_n)
    (!capMaster && ctrlThird[tcc_pkg::CTRL3_CAP1] && flagReg[tcc_pkg::FLG_CAP1])
    |=> captureIrq)
    else $error("Enabled capture channel did not interrupt.");

  // With the master clear, an enabled first compare interrupts on its own.
  a_single_cmp1: assert property (@(posedge clk) disable iff (!arst_n)
    (!cmpMaster && ctrlThird[tcc_pkg::CTRL3_CMP1] && flagReg[tcc_pkg::FLG_CMP1])
    |=> compareIrq)
    else $error("Enabled compare channel did not interrupt.");

  // With the master clear, a disabled first compare stays silent.
  a_single_cmp: assert property (@(posedge clk) disable iff (!arst_n)
    (!cmpMaster && !ctrlThird[tcc_pkg::CTRL3_CMP1] && flagReg[tcc_pkg::FLG_CMP1]
    && !flagReg[tcc_pkg::FLG_CMP2]) |=> !compareIrq)
    else $error("Disabled compare channel raised a request.");

  // No compare request while the compare master and both compare enables are clear.
  a_all_off: assert property (@(posedge clk) disable iff (!arst_n)
    (!cmpMaster && !ctrlThird[tcc_pkg::CTRL3_CMP1] && !ctrlThird[tcc_pkg::CTRL3_CMP2])
    |=> !compareIrq)
    else $error("Compare request with all enables clear.");

  // No capture request while the capture master and both capture enables are clear.
  a_cap_off: assert property (@(posedge clk) disable iff (!arst_n)
    (!capMaster && !ctrlThird[tcc_pkg::CTRL3_CAP1] && !ctrlThird[tcc_pkg::CTRL3_CAP2])
    |=> !captureIrq)
    else $error("Capture request with all enables clear.");

  // In PWM mode a counter match sets the second compare flag.
  a_pwm_hit: assert property (@(posedge clk) disable iff (!arst_n)
    (pwmMode && counterValue == compare2Value) |=> flagReg[tcc_pkg::FLG_CMP2])
    else $error("PWM match did not set compare 2 flag.");

  // Under the compare master a PWM match reaches the compare output two edges on.
  a_pwm_req: assert property (@(posedge clk) disable iff (!arst_n)
    (pwmMode && compare2Hit && cmpMaster && !apbWrite) |-> ##2 compareIrq)
    else $error("PWM match under master gave no request.");

  // With only the second compare enable set a PWM match still interrupts.
  a_pwm_chan: assert property (@(posedge clk) disable iff (!arst_n)
    (pwmMode && compare2Hit && ctrlThird[tcc_pkg::CTRL3_CMP2] && !apbWrite)
    |-> ##2 compareIrq)
    else $error("PWM match under channel enable gave no request.");

  // A set second compare flag interrupts under either compare enable.
  a_pwm_enable: assert property (@(posedge clk) disable iff (!arst_n)
    (flagReg[tcc_pkg::FLG_CMP2] && (cmpMaster || ctrlThird[tcc_pkg::CTRL3_CMP2]))
    |=> compareIrq)
    else $error("PWM match request missing.");

  // The match request is suppressed when both compare 2 enables are clear.
  a_pwm_off: assert property (@(posedge clk) disable iff (!arst_n)
    (!cmpMaster && !ctrlThird[tcc_pkg::CTRL3_CMP2]
    && !(flagReg[tcc_pkg::FLG_CMP1] && ctrlThird[tcc_pkg::CTRL3_CMP1])) |=> !compareIrq)
    else $error("PWM match request not suppressed.");

  // The per-channel enables land in the upper nibble; the lower nibble stays clear.
  a_ctrl3_pos: assert property (@(posedge clk) disable iff (!arst_n)
    (apbWrite && paddr == tcc_pkg::OFS_CTRL3) |=>
    (ctrlThird == {$past(pwdata[tcc_pkg::CTRL3_CAP1:tcc_pkg::CTRL3_CMP2]), 4'h0}))
    else $error("Per-channel enables stored at wrong bits.");

  // The first control word stores the masters and the PWM select.
  a_ctrl1_pos: assert property (@(posedge clk) disable iff (!arst_n)
    (apbWrite && paddr == tcc_pkg::OFS_CTRL1) |=>
    (capMaster == $past(pwdata[tcc_pkg::CTRL1_CAP_MASTER])
    && cmpMaster == $past(pwdata[tcc_pkg::CTRL1_CMP_MASTER])
    && pwmMode == $past(pwdata[tcc_pkg::CTRL1_PWM])))
    else $error("Master enables stored at wrong bits.");

  // In PWM mode hardware never sets the first compare flag.
  a_pwm_no_cmp1: assert property (@(posedge clk) disable iff (!arst_n)
    (pwmMode && !flagReg[tcc_pkg::FLG_CMP1]) |=> !flagReg[tcc_pkg::FLG_CMP1])
    else $error("Compare 1 flag set in PWM mode.");

  // Outside PWM mode a first compare match sets its flag.
  a_cmp1_hw: assert property (@(posedge clk) disable iff (!arst_n)
    (compare1Match && !pwmMode) |=> flagReg[tcc_pkg::FLG_CMP1])
    else $error("Compare 1 match did not set its flag.");

  // An unmasked request drives the summary output one edge later.
  a_irq_on: assert property (@(posedge clk) disable iff (!arst_n)
    (|(fl.request & irqEnable)) |=> irq)
    else $error("Summary interrupt missing.");

  // Without an unmasked request the summary output is low.
  a_irq_off: assert property (@(posedge clk) disable iff (!arst_n)
    (!(|(fl.request & irqEnable))) |=> !irq)
    else $error("Summary interrupt without a request.");

  // Read data holds through the access phase of a read.
  a_read_hold: assert property (@(posedge clk) disable iff (!arst_n)
    apbRead |=> (prdata == $past(prdata)))
    else $error("Read data changed during the access phase.");

  // Per-flag bookkeeping: a set wins, a lone clear empties, and flags are sticky.
  for (genvar k = 0; k < tcc_pkg::NUM_FLAGS; k++) begin : g_flag_chk
    // An event leaves its flag set, even against a clear in the same cycle.
    a_set_wins: assert property (@(posedge clk) disable iff (!arst_n)
      setVec[k] |=> flagReg[k])
      else $error("Event did not set its flag.");
    // A clear without an event empties the flag.
    a_clear_flag: assert property (@(posedge clk) disable iff (!arst_n)
      (clrVec[k] && !setVec[k]) |=> !flagReg[k])
      else $error("Clear did not empty the flag.");
    // Without a clear a set flag stays set.
    a_flag_sticky: assert property (@(posedge clk) disable iff (!arst_n)
      (flagReg[k] && !clrVec[k]) |=> flagReg[k])
      else $error("Flag dropped without a clear.");
  end

endmodule // tcc_core

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
// Self-checking bench for the capture and compare interrupt gating block.
module tb_top;
  // ------------------------------------------------------------
  // Signals and counters
  // ------------------------------------------------------------
  localparam logic [15:0] MATCH = 16'h0055;  // Second compare value used throughout.
  logic clk = 1'b0;  // 50 MHz clock.
  logic arst_n = 1'b0;  // Active-low reset.
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;  // APB control.
  logic [7:0] paddr = 8'h00;  // APB address.
  logic [31:0] pwdata = 32'h0, prdata, rd;  // APB data and last read word.
  logic pready, pslverr, pwmMode, captureIrq, compareIrq, irq;  // Block outputs.
  logic capture1Event = 1'b0, capture2Event = 1'b0, compare1Match = 1'b0;  // Events.
  logic [15:0] counterValue = 16'hFFFF, compare2Value;  // Idle counter never matches.
  logic irqOn = 1'b1;  // Whether the summary output is unmasked.
  int fails = 0;  // Mismatches seen.
  int checks = 0;  // Comparisons made.

  always #10 clk = ~clk;

  tcc_core #(.CNT_W(16)) uut (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .capture1Event(capture1Event), .capture2Event(capture2Event),
    .compare1Match(compare1Match), .counterValue(counterValue), .pwmMode(pwmMode),
    .compare2Value(compare2Value), .captureIrq(captureIrq), .compareIrq(compareIrq),
    .irq(irq));

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  // Compares a seen value with the expected one and reports a mismatch.
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic finish_test();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // One APB transfer; the request is held until pready is seen high.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (n = 0; n < 8; n++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (n == 8) begin
      fails++;
      finish_test();
    end
    rd = prdata;
    chk("pslverr", {31'h0, pslverr}, 32'h0);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Configures enables, fires the chosen events, then checks requests and flags.
  task automatic run(input logic [2:0] c1, input logic [3:0] en, input logic [3:0] ev);
    logic [3:0] fl, rq;
    logic ec, em;
    apb(1'b1, tcc_pkg::OFS_CTRL1, {29'h0, c1});
    apb(1'b1, tcc_pkg::OFS_CTRL3, {24'h0, en[0], en[2], en[1], en[3], 4'h0});
    apb(1'b1, tcc_pkg::OFS_CLEAR, 32'h0000_000F);
    @(posedge clk);
    capture1Event <= ev[0];
    capture2Event <= ev[1];
    compare1Match <= ev[2];
    counterValue <= ev[3] ? MATCH : 16'hFFFF;
    @(posedge clk);
    capture1Event <= 1'b0;
    capture2Event <= 1'b0;
    compare1Match <= 1'b0;
    counterValue <= 16'hFFFF;
    repeat (3) @(posedge clk);
    #1;
    fl = ev;
    if (c1[2]) fl[2] = 1'b0;
    rq = fl & {c1[1] | en[3], c1[1] | en[2], c1[0] | en[1], c1[0] | en[0]};
    ec = |rq[1:0];
    em = |rq[3:2];
    chk("captureIrq", {31'h0, captureIrq}, {31'h0, ec});
    chk("compareIrq", {31'h0, compareIrq}, {31'h0, em});
    chk("irq", {31'h0, irq}, {31'h0, (ec | em) & irqOn});
    chk("pwmMode", {31'h0, pwmMode}, {31'h0, c1[2]});
    apb(1'b0, tcc_pkg::OFS_STATUS, 32'h0);
    chk("status", rd, {28'h0, fl});
    apb(1'b0, tcc_pkg::OFS_REQ, 32'h0);
    chk("requests", rd, {28'h0, rq});
    apb(1'b1, tcc_pkg::OFS_CLEAR, 32'h0000_000F);
    repeat (2) @(posedge clk);
    #1;
    chk("cleared", {29'h0, captureIrq, compareIrq, irq}, 32'h0);
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  // Reset values, field width of the channel enables and an unmapped place.
  task automatic t_reset();
    chk("irqs at reset", {29'h0, captureIrq, compareIrq, irq}, 32'h0);
    apb(1'b0, tcc_pkg::OFS_STATUS, 32'h0);
    chk("status reset", rd, tcc_pkg::RST_ZERO);
    apb(1'b1, tcc_pkg::OFS_CTRL3, 32'h0000_00FF);
    apb(1'b0, tcc_pkg::OFS_CTRL3, 32'h0);
    chk("ctrl3 bits", rd, 32'h0000_00F0);
    apb(1'b1, 8'h1C, 32'hFFFF_FFFF);
    apb(1'b0, 8'h1C, 32'h0);
    chk("unmapped", rd, 32'h0);
    apb(1'b1, tcc_pkg::OFS_CMP2, {16'h0, MATCH});
    apb(1'b1, tcc_pkg::OFS_IRQEN, 32'h0000_000F);
    chk("compare2Value", {16'h0, compare2Value}, {16'h0, MATCH});
  endtask

  // Master enables cover both channels whatever the channel enables say.
  task automatic t_master();
    run(3'b011, 4'h0, 4'hF);
    run(3'b001, 4'hF, 4'hF);
  endtask

  // With masters cleared, each channel interrupts alone through its own enable.
  task automatic t_single();
    for (int i = 0; i < 4; i++) begin
      run(3'b000, 4'(1 << i), 4'hF);
      run(3'b000, 4'(1 << i), ~4'(1 << i));
    end
    run(3'b000, 4'h0, 4'hF);
  endtask

  // Counter match in PWM mode, and the first compare flag staying clear.
  task automatic t_pwm();
    run(3'b100, 4'h0, 4'hC);
    run(3'b110, 4'h0, 4'hC);
    run(3'b100, 4'h8, 4'hC);
    run(3'b101, 4'h7, 4'h8);
  endtask

  // Summary output masked while its enable is clear.
  task automatic t_mask();
    apb(1'b1, tcc_pkg::OFS_IRQEN, 32'h0);
    irqOn = 1'b0;
    run(3'b011, 4'h0, 4'hF);
    apb(1'b1, tcc_pkg::OFS_IRQEN, 32'h0000_000F);
    irqOn = 1'b1;
  endtask

  // Reset for 16 cycles, then every scenario in turn.
  initial begin
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    t_reset();
    t_master();
    t_single();
    t_pwm();
    t_mask();
    finish_test();
  end
endmodule  // tb_top
